// ---- common/pdpwm_pkg.sv ----
// Shared constants, types and decode for the pulse division PWM block
// Assumes one 100 MHz system clock and an Avalon-MM host with 32-bit data
// How it works
// - Clock select 0 runs the generator on system clock over two, period 16384 clocks.
// - Clock select 1 runs it on system clock over four, period 32768 clocks.
// - Control bits 7 to 1 read as ones and ignore writes; only bit 0 is writable.
// - The width value is 14 bits: 6 in the upper data register, 8 in the lower.
// - Reading either data register always returns all ones.
// - Lower byte first; writing the upper byte latches all 14 bits, applied at a period edge.
// - After reset the combined data pair holds c000, the least high width.
// - One conversion period is made of 64 pulses.
// - High time per period equals the value plus 64, times half the input clock period.
// - Values from ffc0 to ffff keep the output high all the time.
`default_nettype none

package pdpwm_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned PDPWM_DATA_W     = 14;
   localparam int unsigned PDPWM_UPPER_W    = 6;
   localparam int unsigned PDPWM_LOWER_W    = 8;
   localparam int unsigned PDPWM_PULSE_BITS = 6;
   localparam int unsigned PDPWM_POS_BITS   = 8;

   // ----------------------------------------------------------------
   // Register map, byte addresses, one word each
   // ----------------------------------------------------------------
   localparam logic [3:0] PDPWM_OFF_CTRL   = 4'h0;
   localparam logic [3:0] PDPWM_OFF_LOWER  = 4'h4;
   localparam logic [3:0] PDPWM_OFF_UPPER  = 4'h8;
   localparam logic [3:0] PDPWM_OFF_STATUS = 4'hc;

   // One-hot select positions returned by the decoder
   localparam int unsigned PDPWM_SEL_CTRL   = 0;
   localparam int unsigned PDPWM_SEL_LOWER  = 1;
   localparam int unsigned PDPWM_SEL_UPPER  = 2;
   localparam int unsigned PDPWM_SEL_STATUS = 3;

   // ----------------------------------------------------------------
   // Fields and values
   // ----------------------------------------------------------------
   localparam int unsigned PDPWM_CTRL_SEL_BIT  = 0;
   localparam int unsigned PDPWM_STAT_PEND_BIT = 0;
   localparam int unsigned PDPWM_STAT_LVL_BIT  = 1;
   localparam logic [6:0]  PDPWM_CTRL_RSVD     = 7'h7f;
   localparam logic [7:0]  PDPWM_DATA_READ     = 8'hff;
   localparam logic        PDPWM_SEL_RESET     = 1'b0;
   localparam logic [15:0] PDPWM_WIDTH_RESET   = 16'hc000;
   localparam logic [1:0]  PDPWM_TOP_ONES      = 2'h3;
   localparam logic [13:0] PDPWM_FULL_MIN      = 14'h3fc0;
   localparam int unsigned PDPWM_H_OFFSET      = 64;

   // ----------------------------------------------------------------
   // Types and decode
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PDPWM_BUS_IDLE = 2'b01,
      PDPWM_BUS_ANS  = 2'b10
   } pdpwm_bus_t;

   // Aligned address to one-hot register select, zero when unmapped
   function automatic logic [3:0] pdpwm_decode(input logic [3:0] addr);
      logic [3:0] sel;
      sel = 4'h0;
      sel[PDPWM_SEL_CTRL]   = (addr == PDPWM_OFF_CTRL);
      sel[PDPWM_SEL_LOWER]  = (addr == PDPWM_OFF_LOWER);
      sel[PDPWM_SEL_UPPER]  = (addr == PDPWM_OFF_UPPER);
      sel[PDPWM_SEL_STATUS] = (addr == PDPWM_OFF_STATUS);
      return sel;
   endfunction : pdpwm_decode

endpackage : pdpwm_pkg

`default_nettype wire

// ---- hw/pdpwm_clkdiv.sv ----
// Divider giving the half input clock period enable of the PWM
// Assumes the select is a registered control bit in the same clock domain
`timescale 1ns/1ps
`default_nettype none

module pdpwm_clkdiv
   import pdpwm_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic div4_sel,
   output logic      unit_en
);

   logic phase_q;
   logic phase_d;

   // Half of phi/2 is every clock, half of phi/4 is every other clock
   always_comb
   begin
      phase_d = div4_sel ? ~phase_q : 1'b0;
      unit_en = div4_sel ? phase_q : 1'b1;
   end

   // Phase register
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         phase_q <= 1'b0;
      else
         phase_q <= phase_d;
   end

endmodule : pdpwm_clkdiv

`default_nettype wire

// ---- hw/pdpwm_wave.sv ----
// Pulse division waveform generator with staged and active width values
// Assumes unit_en marks one half period of the PWM input clock
`timescale 1ns/1ps
`default_nettype none

module pdpwm_wave
   import pdpwm_pkg::*;
#(
   parameter int unsigned PULSE_BITS = PDPWM_PULSE_BITS,
   parameter int unsigned POS_BITS   = PDPWM_POS_BITS
)
(
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   input  wire logic                    unit_en,
   input  wire logic                    load_req,
   input  wire logic [PDPWM_DATA_W-1:0] load_value,
   output logic                         pwm_level,
   output logic                         update_pending
);

   localparam int unsigned CNT_W = PULSE_BITS + POS_BITS;
   localparam int unsigned H_W   = CNT_W + 1;
   localparam int unsigned WID_W = POS_BITS + 2;

   if (CNT_W != PDPWM_DATA_W)
   begin : g_bad_split
      $error("pulse and position bits must add up to the data width");
   end

   logic [CNT_W-1:0]      cnt_q, cnt_d, active_q, active_d, staged_q, staged_d;
   logic                  pending_q, pending_d, out_q, out_d;
   logic [PULSE_BITS-1:0] idx, idx_rev;
   logic [POS_BITS-1:0]   pos;
   logic [H_W-1:0]        h_val, acc_q, acc_d;
   logic [WID_W-1:0]      width, pacc_q, pacc_d;
   logic                  level_now, period_end;

   // Pulse index in the top bits, position inside the pulse below
   assign idx = cnt_q[CNT_W-1:POS_BITS];
   assign pos = cnt_q[POS_BITS-1:0];
   for (genvar i = 0; i < PULSE_BITS; i++)
   begin : g_rev
      assign idx_rev[i] = idx[PULSE_BITS-1-i];
   end

   // Spread value plus 64 units: base per pulse, remainder by bit-reversed index
   assign h_val      = {1'b0, active_q} + H_W'(PDPWM_H_OFFSET);
   assign width      = {1'b0, h_val[H_W-1:PULSE_BITS]}
                       + WID_W'(idx_rev < h_val[PULSE_BITS-1:0]);
   assign level_now  = {2'b00, pos} < width;
   assign period_end = unit_en & (&cnt_q);

   // Counter, output, value staging and period-edge update
   always_comb
   begin
      cnt_d     = unit_en ? CNT_W'(cnt_q + 1'b1) : cnt_q;
      out_d     = unit_en ? level_now : out_q;
      staged_d  = load_req ? load_value : staged_q;
      active_d  = (period_end & pending_q) ? staged_q : active_q;
      pending_d = load_req | (pending_q & ~period_end);
      acc_d     = unit_en ? ((&cnt_q) ? '0 : H_W'(acc_q + level_now)) : acc_q;
      pacc_d    = unit_en ? ((&pos) ? '0 : WID_W'(pacc_q + level_now)) : pacc_q;
   end

   // State registers
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cnt_q     <= '0;
         out_q     <= 1'b0;
         staged_q  <= PDPWM_WIDTH_RESET[PDPWM_DATA_W-1:0];
         active_q  <= PDPWM_WIDTH_RESET[PDPWM_DATA_W-1:0];
         pending_q <= 1'b0;
         acc_q     <= '0;
         pacc_q    <= '0;
      end
      else
      begin
         cnt_q     <= cnt_d;
         out_q     <= out_d;
         staged_q  <= staged_d;
         active_q  <= active_d;
         pending_q <= pending_d;
         acc_q     <= acc_d;
         pacc_q    <= pacc_d;
      end
   end

   assign pwm_level      = out_q;
   assign update_pending = pending_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   period_total_a: assert property (@(posedge clock) disable iff (!rst_n)
      period_end |-> (H_W'(acc_q + level_now) == ((h_val > H_W'(1 << CNT_W))
                      ? H_W'(1 << CNT_W) : h_val)))
      else $error("high time per period is wrong");
   pulse_even_a: assert property (@(posedge clock) disable iff (!rst_n)
      (unit_en && (&pos)) |-> (WID_W'(pacc_q + level_now) == ((width > WID_W'(1 << POS_BITS))
                               ? WID_W'(1 << POS_BITS) : width)))
      else $error("pulse high time not evenly spread");
   pulse_start_a: assert property (@(posedge clock) disable iff (!rst_n)
      (unit_en && pos == '0) |=> pwm_level)
      else $error("a pulse did not start high");
   full_high_a: assert property (@(posedge clock) disable iff (!rst_n)
      (unit_en && active_q >= PDPWM_FULL_MIN) |=> pwm_level)
      else $error("output dropped for a full-scale value");

endmodule : pdpwm_wave

`default_nettype wire

// ---- hw/pdpwm_top.sv ----
// Pulse division PWM: Avalon-MM register slave, divider and waveform generator
// Assumes one 100 MHz clock, a synchronous active-low reset and
// a port block outside that owns the shared pin routing select
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pdpwm_top
   import pdpwm_pkg::*;
#(
   parameter int unsigned PULSE_BITS = PDPWM_PULSE_BITS,
   parameter int unsigned POS_BITS   = PDPWM_POS_BITS
)
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        pwm_pin_function_select,
   output logic             pwm_out,
   output logic             pwm_out_oe
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (PULSE_BITS + POS_BITS != PDPWM_DATA_W)
   begin : g_bad_split
      $error("pulse and position bits must add up to 14");
   end
   if (PDPWM_UPPER_W + PDPWM_LOWER_W != PDPWM_DATA_W)
   begin : g_bad_bytes
      $error("data byte widths must add up to 14");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   pdpwm_bus_t               bus_q;
   pdpwm_bus_t               bus_d;
   logic [31:0]              rdata_q;
   logic [31:0]              rdata_d;
   logic [31:0]              rd_word;
   logic                     ctrl_sel_q;
   logic                     ctrl_sel_d;
   logic [PDPWM_LOWER_W-1:0] lower_q;
   logic [PDPWM_LOWER_W-1:0] lower_d;
   logic [PDPWM_UPPER_W-1:0] upper_q;
   logic [PDPWM_UPPER_W-1:0] upper_d;
   logic [PDPWM_DATA_W-1:0]  load_value;
   logic [3:0]               reg_sel;
   logic                     req;
   logic                     take;
   logic                     wr_ok;
   logic                     load_req;
   logic                     unit_en;
   logic                     wave_level;
   logic                     update_pending;

   // ----------------------------------------------------------------
   // Bus request decode
   // ----------------------------------------------------------------

   // A request is answered in the cycle after it is first seen
   assign req             = avs_read | avs_write;
   assign take            = req & (bus_q == PDPWM_BUS_ANS);
   assign avs_waitrequest = req & (bus_q != PDPWM_BUS_ANS);
   assign reg_sel         = pdpwm_decode(avs_address);

   // Only the low byte lane carries a register; other lanes are dropped
   assign wr_ok = take & avs_write & avs_byteenable[0];

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------

   // Read word; unmapped addresses read zero
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (reg_sel[PDPWM_SEL_CTRL])
         rd_word[7:0] = {PDPWM_CTRL_RSVD, ctrl_sel_q};
      if (reg_sel[PDPWM_SEL_LOWER] | reg_sel[PDPWM_SEL_UPPER])
         rd_word[7:0] = PDPWM_DATA_READ;
      if (reg_sel[PDPWM_SEL_STATUS])
      begin
         rd_word[PDPWM_STAT_PEND_BIT] = update_pending;
         rd_word[PDPWM_STAT_LVL_BIT]  = wave_level;
      end
   end

   // ----------------------------------------------------------------
   // Bus state and register writes
   // ----------------------------------------------------------------

   // Next bus state, read capture and register updates
   always_comb
   begin
      bus_d      = bus_q;
      rdata_d    = rdata_q;
      ctrl_sel_d = ctrl_sel_q;
      lower_d    = lower_q;
      upper_d    = upper_q;
      unique case (bus_q)
         PDPWM_BUS_IDLE:
         begin
            if (req)
            begin
               bus_d = PDPWM_BUS_ANS;
               if (avs_read)
                  rdata_d = rd_word;
            end
         end
         PDPWM_BUS_ANS:
         begin
            bus_d = PDPWM_BUS_IDLE;
         end
         default:
         begin
            bus_d = PDPWM_BUS_IDLE;
         end
      endcase
      if (wr_ok & reg_sel[PDPWM_SEL_CTRL])
         ctrl_sel_d = avs_writedata[PDPWM_CTRL_SEL_BIT];
      if (wr_ok & reg_sel[PDPWM_SEL_LOWER])
         lower_d = avs_writedata[PDPWM_LOWER_W-1:0];
      if (wr_ok & reg_sel[PDPWM_SEL_UPPER])
         upper_d = avs_writedata[PDPWM_UPPER_W-1:0];
   end

   // Registers of the slave
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         bus_q      <= PDPWM_BUS_IDLE;
         rdata_q    <= 32'h0000_0000;
         ctrl_sel_q <= PDPWM_SEL_RESET;
         lower_q    <= PDPWM_WIDTH_RESET[PDPWM_LOWER_W-1:0];
         upper_q    <= PDPWM_WIDTH_RESET[PDPWM_DATA_W-1:PDPWM_LOWER_W];
      end
      else
      begin
         bus_q      <= bus_d;
         rdata_q    <= rdata_d;
         ctrl_sel_q <= ctrl_sel_d;
         lower_q    <= lower_d;
         upper_q    <= upper_d;
      end
   end

   assign avs_readdata = rdata_q;

   // ----------------------------------------------------------------
   // Value hand-off
   // ----------------------------------------------------------------

   // Upper byte write carries the held lower byte along with it
   assign load_req   = wr_ok & reg_sel[PDPWM_SEL_UPPER];
   assign load_value = {avs_writedata[PDPWM_UPPER_W-1:0], lower_q};

   // ----------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------

   // Half input period enable from the clock select
   pdpwm_clkdiv u_clkdiv (
      .clock    (clock),
      .rst_n    (rst_n),
      .div4_sel (ctrl_sel_q),
      .unit_en  (unit_en)
   );

   // Waveform generator
   pdpwm_wave #(
      .PULSE_BITS (PULSE_BITS),
      .POS_BITS   (POS_BITS)
   ) u_wave (
      .clock          (clock),
      .rst_n          (rst_n),
      .unit_en        (unit_en),
      .load_req       (load_req),
      .load_value     (load_value),
      .pwm_level      (wave_level),
      .update_pending (update_pending)
   );

   // Pin drive follows the port routing select; routing is set first by software
   assign pwm_out    = wave_level;
   assign pwm_out_oe = pwm_pin_function_select;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   ans_next_a: assert property (@(posedge clock) disable iff (!rst_n)
      (req && bus_q == PDPWM_BUS_IDLE) |=> !avs_waitrequest)
      else $error("bus answer not given in the next cycle");

   div2_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
      (!ctrl_sel_q) |-> unit_en)
      else $error("divide by two enable missing");

   div4_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
      (ctrl_sel_q && $past(ctrl_sel_q)) |-> (unit_en != $past(unit_en)))
      else $error("divide by four enable does not alternate");

   ctrl_read_a: assert property (@(posedge clock) disable iff (!rst_n)
      (take && avs_read && reg_sel[PDPWM_SEL_CTRL])
         |-> (avs_readdata == {24'h00_0000, PDPWM_CTRL_RSVD, ctrl_sel_q}))
      else $error("control read does not show ones above the select");

   ctrl_write_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_ok && reg_sel[PDPWM_SEL_CTRL])
         |=> (ctrl_sel_q == $past(avs_writedata[PDPWM_CTRL_SEL_BIT])))
      else $error("clock select not written");

   data_read_a: assert property (@(posedge clock) disable iff (!rst_n)
      (take && avs_read && (reg_sel[PDPWM_SEL_LOWER] || reg_sel[PDPWM_SEL_UPPER]))
         |-> (avs_readdata == {24'h00_0000, PDPWM_DATA_READ}))
      else $error("data register read is not all ones");

   lower_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_ok && reg_sel[PDPWM_SEL_LOWER])
         |-> !load_req ##1 (lower_q == $past(avs_writedata[7:0])))
      else $error("lower byte not held or loaded early");

   upper_load_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_ok && reg_sel[PDPWM_SEL_UPPER])
         |-> (load_req && load_value == {avs_writedata[5:0], lower_q}))
      else $error("upper write did not hand over the full value");

   pend_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      load_req |=> update_pending
         ##1 (update_pending || $past(u_wave.period_end)))
      else $error("loaded value not pending for the period edge");

   reset_value_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(rst_n) |-> ({PDPWM_TOP_ONES, upper_q, lower_q} == PDPWM_WIDTH_RESET))
      else $error("data pair does not reset to the least width");

   pin_enable_a: assert property (@(posedge clock) disable iff (!rst_n)
      pwm_out_oe == pwm_pin_function_select)
      else $error("pin enable does not follow routing select");

   cover_slow_load_c: cover property (@(posedge clock) disable iff (!rst_n)
      ctrl_sel_q && load_req);
   cover_ctrl_read_c: cover property (@(posedge clock) disable iff (!rst_n)
      take && avs_read && reg_sel[PDPWM_SEL_CTRL]);
   cover_applied_c: cover property (@(posedge clock) disable iff (!rst_n)
      $fell(update_pending));
   cover_high_run_c: cover property (@(posedge clock) disable iff (!rst_n)
      wave_level [*8]);
   cover_status_read_c: cover property (@(posedge clock) disable iff (!rst_n)
      take && avs_read && reg_sel[PDPWM_SEL_STATUS]);

   // ----------------------------------------------------------------
   // Protocol and hold checks
   // ----------------------------------------------------------------

   // An idle bus never stalls, and every fresh request waits one cycle
   idle_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
      (!req)
         |-> !avs_waitrequest)
      else $error("waitrequest raised with no request");

   first_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
      (req && bus_q == PDPWM_BUS_IDLE)
         |-> avs_waitrequest)
      else $error("request answered without its wait cycle");

   // Read data stand until the next read is captured
   rdata_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      !(avs_read && bus_q == PDPWM_BUS_IDLE)
         |=> $stable(avs_readdata))
      else $error("read data changed without a read");

   status_read_a: assert property (@(posedge clock) disable iff (!rst_n)
      (take && avs_read && reg_sel[PDPWM_SEL_STATUS])
         |-> (avs_readdata == {30'h0, $past(wave_level), $past(update_pending)}))
      else $error("status read does not match pending and level");

   unmapped_read_a: assert property (@(posedge clock) disable iff (!rst_n)
      (take && avs_read && reg_sel == 4'h0)
         |-> (avs_readdata == 32'h0000_0000))
      else $error("unmapped read is not zero");

   // Registers move only on their own accepted write
   ctrl_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
      !(wr_ok && reg_sel[PDPWM_SEL_CTRL])
         |=> $stable(ctrl_sel_q))
      else $error("clock select changed without a write");

   lower_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
      !(wr_ok && reg_sel[PDPWM_SEL_LOWER])
         |=> $stable(lower_q))
      else $error("lower byte changed without a write");

   upper_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
      !(wr_ok && reg_sel[PDPWM_SEL_UPPER])
         |=> $stable(upper_q))
      else $error("upper bits changed without a write");

   // Nothing is waiting for a period edge unless an upper write put it there
   pend_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
      (!load_req && !update_pending)
         |=> !update_pending)
      else $error("update pending without an upper write");

endmodule : pdpwm_top

`default_nettype wire

// ---- testbench/pdpwm_filter_model.sv ----
// Filter side model: integrates the PWM pin over a measuring window
// Assumes the pin is pulled low while the block does not drive it
`timescale 1ns/1ps
`default_nettype none

module pdpwm_filter_model
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic pwm_in,
   input  wire logic drive_en,
   input  wire logic clear,
   output var int    cycles,
   output var int    high_cnt,
   output var int    rises,
   output var int    min_run,
   output var int    max_run
);
   logic pin;
   logic prev;
   logic valid;
   int   run = 0;

   // Pin level seen by the filter, pulled low when undriven
   assign pin = drive_en ? pwm_in : 1'b0;

   // Window counters; a run counts only if its rise fell inside the window
   always @(posedge clock)
   begin
      prev <= pin;
      run  <= pin ? run + 1 : 0;
      if (!rst_n || clear)
      begin
         cycles   <= 0;
         high_cnt <= 0;
         rises    <= 0;
         min_run  <= 1000000;
         max_run  <= 0;
         valid    <= 1'b0;
      end
      else
      begin
         cycles   <= cycles + 1;
         high_cnt <= high_cnt + (pin ? 1 : 0);
         if (pin && !prev)
         begin
            rises <= rises + 1;
            valid <= 1'b1;
         end
         if (!pin && prev && valid)
         begin
            if (run < min_run) min_run <= run;
            if (run > max_run) max_run <= run;
         end
      end
   end
endmodule : pdpwm_filter_model

`default_nettype wire

// ---- testbench/pdpwm_top_test.sv ----
// Self-checking bench for the pulse division PWM top
// Assumes the filter model sits on the PWM pin
`timescale 1ns/1ps
`default_nettype none

module pdpwm_top_test
   import pdpwm_pkg::*;
();
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        pin_sel = 1'b0;
   logic        pwm_out;
   logic        pwm_out_oe;
   logic        clear = 1'b0;
   logic [31:0] rd;
   int          cycles, high_cnt, rises, min_run, max_run;
   int          bad_count = 0;
   int          checks = 0;
   int          d;

   always #5 clock = ~clock;

   pdpwm_top dut_u (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pwm_pin_function_select(pin_sel),
      .pwm_out(pwm_out), .pwm_out_oe(pwm_out_oe));

   pdpwm_filter_model filt_u (.clock(clock), .rst_n(rst_n), .pwm_in(pwm_out),
      .drive_en(pwm_out_oe), .clear(clear), .cycles(cycles), .high_cnt(high_cnt),
      .rises(rises), .min_run(min_run), .max_run(max_run));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // One byte transfer, entered just after a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] wd,
                      input logic [3:0] be);
      int n;
      n = 0;
      avs_address    <= a;
      avs_writedata  <= {24'h0, wd};
      avs_byteenable <= be;
      avs_read       <= ~wr;
      avs_write      <= wr;
      do
      begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      if (n >= 50) check("waitrequest", 1'b1, 1'b0);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask : bus

   // Lower byte first, then upper; poll until the generator takes it
   task automatic write_width(input int dv, input logic [1:0] top);
      int k;
      k = 0;
      bus(1'b1, PDPWM_OFF_LOWER, dv[7:0], 4'h1);
      bus(1'b1, PDPWM_OFF_UPPER, {top, dv[13:8]}, 4'h1);
      do
      begin
         bus(1'b0, PDPWM_OFF_STATUS, 8'h00, 4'h1);
         k++;
      end while (rd[PDPWM_STAT_PEND_BIT] !== 1'b0 && k < 20000);
      check("update applied", k < 20000, 1'b1);
   endtask : write_width

   // Integrate one window and compare against the width formula
   task automatic measure(input int n, input int dv, input int unit);
      int h;
      h = dv + 64;
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
      repeat (n) @(posedge clock);
      @(negedge clock);
      check("window", cycles, n);
      if (dv >= 'h3fc0)
      begin
         check("steady high", high_cnt, n);
         check("no pulses", rises, 0);
      end
      else
      begin
         check("high time", high_cnt, h * unit);
         check("pulse count", rises, 64);
         check("shortest pulse", min_run >= (h / 64) * unit, 1'b1);
         check("longest pulse", max_run <= ((h + 63) / 64) * unit, 1'b1);
      end
      @(posedge clock);
   endtask : measure

   task automatic results();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(92885));
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      check("pin enable off", pwm_out_oe, 1'b0);
      pin_sel <= 1'b1;
      bus(1'b0, PDPWM_OFF_CTRL, 8'h00, 4'h1);
      check("control reset", rd, 32'hfe);
      bus(1'b0, PDPWM_OFF_LOWER, 8'h00, 4'h1);
      check("lower read", rd, 32'hff);
      bus(1'b0, PDPWM_OFF_UPPER, 8'h00, 4'h1);
      check("upper read", rd, 32'hff);
      bus(1'b0, 4'h2, 8'h00, 4'h1);
      check("unmapped read", rd, 32'h0);
      bus(1'b1, PDPWM_OFF_CTRL, 8'h01, 4'h0);
      bus(1'b0, PDPWM_OFF_CTRL, 8'h00, 4'h1);
      check("control masked", rd, 32'hfe);
      check("pin enable on", pwm_out_oe, 1'b1);
      measure(16384, 0, 1);
      $display("test reset value done");
      bus(1'b1, PDPWM_OFF_CTRL, 8'h01, 4'h1);
      bus(1'b0, PDPWM_OFF_CTRL, 8'h00, 4'h1);
      check("control select", rd, 32'hff);
      measure(32768, 0, 2);
      $display("test slow clock done");
      bus(1'b1, PDPWM_OFF_CTRL, 8'h00, 4'h1);
      // Above 16256 whole pulses run high and merge, which the pulse checks do not model
      d = $urandom_range(16255, 0);
      write_width(d, 2'($urandom_range(3, 0)));
      bus(1'b0, PDPWM_OFF_UPPER, 8'h00, 4'h1);
      check("upper read", rd, 32'hff);
      measure(16384, d, 1);
      $display("test random width done");
      d = 'h3fc0 + $urandom_range(63, 0);
      write_width(d, 2'h3);
      repeat (4) @(posedge clock);
      measure(1024, d, 1);
      bus(1'b0, PDPWM_OFF_STATUS, 8'h00, 4'h1);
      check("status level", rd, 32'h2);
      $display("test full width done");
      results();
   end

   // Watchdog cuts a hang short
   initial
   begin
      repeat (105000) @(posedge clock);
      bad_count++;
      $display("mismatch watchdog expected done seen timeout");
      results();
   end
endmodule : pdpwm_top_test

`default_nettype wire
